/* File: hw/ltxs_cfg.svh */
// Offsets, field positions, codes and reset values of the link transmit status block
`ifndef LTXS_CFG_SVH
`define LTXS_CFG_SVH
`define LTXS_ADDR_W 8
`define LTXS_OFF_STAT 8'h00
`define LTXS_OFF_CTRL 8'h04
`define LTXS_OFF_CMD 8'h08
`define LTXS_OFF_ERR 8'h0C
`define LTXS_CTRL_PRESENT 0
`define LTXS_BIT_STOP 3
`define LTXS_BIT_ACTIVE 2
`define LTXS_BIT_ACK 1
`define LTXS_BIT_TX 0
`define LTXS_CODE_IDLE 4'h0
`define LTXS_CODE_AWAIT_ACK 4'h2
`define LTXS_CODE_BLOCKED 4'h3
`define LTXS_CODE_SENDING 4'h7
`define LTXS_CODE_STOPPED_IDLE 4'h8
`define LTXS_CODE_STOPPED_AWAIT 4'hA
`define LTXS_CODE_STOPPED_LINKED 4'hC
`define LTXS_CODE_STOPPED_LINKED_ACK 4'hE
`define LTXS_CMD_QUEUE_DATA 3'h1
`define LTXS_CMD_RELINK 3'h2
`define LTXS_CMD_STOP 3'h3
`define LTXS_CMD_RELEASE 3'h4
`define LTXS_CMD_DEACTIVATE 3'h5
`define LTXS_CMD_REMOVE 3'h6
`define LTXS_CMD_ESTABLISH 3'h7
`define LTXS_ERR_ARG 6'h00
`define LTXS_STAT_RST 16'h0000
`define LTXS_RESP_OKAY 2'h0
`define LTXS_RESP_SLVERR 2'h2
`endif

/* File: hw/ltxs_pkg.sv */
// Types shared by the link transmit status block
package ltxs_pkg;
  typedef enum logic [2:0] {
    state_idle, state_await_ack, state_blocked, state_sending, state_stopped_idle,
    state_stopped_await_ack, state_stopped_linked, state_stopped_linked_ack
  } ltxs_state_e;
  typedef enum logic [3:0] {
    ev_none, ev_queue_data, ev_relink, ev_stop_iframes, ev_teardown, ev_all_sent,
    ev_ack_more, ev_ack_none, ev_block, ev_unblock, ev_service, ev_reset
  } ltxs_event_e;
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic present;
    ltxs_state_e state;
    logic [15:0] status;
    logic p_reset;
    logic p_tear;
    logic p_cmd;
    ltxs_event_e cmd_ev;
    logic p_sent;
    logic p_ack;
    logic p_svc;
    logic illegal;
    logic [5:0] err_arg;
    logic wb;
    logic relink;
    logic unlink;
    logic tx_ok;
  } ltxs_top_s;
  typedef struct packed {
    logic sticky;
    logic [15:0] count;
  } ltxs_err_s;
endpackage

/* File: hw/ltxs_trans_if.sv */
// Carrier between the status core and its transition table
`timescale 1ns/1ps
interface ltxs_trans_if;
  ltxs_pkg::ltxs_state_e cur;
  ltxs_pkg::ltxs_event_e ev;
  ltxs_pkg::ltxs_state_e nxt;
  logic illegal;
  modport table_side (input cur, input ev, output nxt, output illegal);
  modport core_side (output cur, output ev, input nxt, input illegal);
endinterface

/* File: hw/ltxs_trans.sv */
// Transition table of the transmit status word
`timescale 1ns/1ps
module ltxs_trans (
  ltxs_trans_if.table_side t
);
  logic legal;
  logic is_cmd;

  // One event per cycle; anything not listed leaves the state alone
  always_comb
  begin
    t.nxt = t.cur;
    legal = 1'b0;
    is_cmd = (t.ev == ltxs_pkg::ev_queue_data) || (t.ev == ltxs_pkg::ev_relink) ||
      (t.ev == ltxs_pkg::ev_stop_iframes);
    if (t.ev == ltxs_pkg::ev_reset)
    begin
      t.nxt = ltxs_pkg::state_idle;
    end
    else if (t.ev == ltxs_pkg::ev_teardown)
    begin
      // Linked states keep the link until the transmit task unlinks it
      if (t.cur == ltxs_pkg::state_sending || t.cur == ltxs_pkg::state_stopped_linked ||
          t.cur == ltxs_pkg::state_stopped_linked_ack)
        t.nxt = ltxs_pkg::state_stopped_linked;
      else
        t.nxt = ltxs_pkg::state_stopped_idle;
    end
    else
    begin
      case (t.cur)
        ltxs_pkg::state_idle, ltxs_pkg::state_stopped_idle, ltxs_pkg::state_stopped_linked:
        begin
          if (t.ev == ltxs_pkg::ev_queue_data)
          begin
            t.nxt = ltxs_pkg::state_sending;
            legal = 1'b1;
          end
          else if (t.cur == ltxs_pkg::state_stopped_linked && t.ev == ltxs_pkg::ev_service)
            t.nxt = ltxs_pkg::state_stopped_idle;
        end
        ltxs_pkg::state_await_ack:
        begin
          if (t.ev == ltxs_pkg::ev_relink)
          begin
            t.nxt = ltxs_pkg::state_sending;
            legal = 1'b1;
          end
          else if (t.ev == ltxs_pkg::ev_ack_more)
            t.nxt = ltxs_pkg::state_sending;
          else if (t.ev == ltxs_pkg::ev_ack_none)
            t.nxt = ltxs_pkg::state_idle;
        end
        ltxs_pkg::state_blocked:
        begin
          legal = (t.ev == ltxs_pkg::ev_relink);
          if (t.ev == ltxs_pkg::ev_stop_iframes)
          begin
            t.nxt = ltxs_pkg::state_stopped_await_ack;
            legal = 1'b1;
          end
          else if (t.ev == ltxs_pkg::ev_unblock)
            t.nxt = ltxs_pkg::state_sending;
        end
        ltxs_pkg::state_sending:
        begin
          legal = (t.ev == ltxs_pkg::ev_relink);
          if (t.ev == ltxs_pkg::ev_stop_iframes)
          begin
            t.nxt = ltxs_pkg::state_stopped_linked_ack;
            legal = 1'b1;
          end
          else if (t.ev == ltxs_pkg::ev_all_sent)
            t.nxt = ltxs_pkg::state_await_ack;
          else if (t.ev == ltxs_pkg::ev_block)
            t.nxt = ltxs_pkg::state_blocked;
        end
        ltxs_pkg::state_stopped_await_ack, ltxs_pkg::state_stopped_linked_ack:
        begin
          if (t.ev == ltxs_pkg::ev_ack_more || t.ev == ltxs_pkg::ev_ack_none)
            t.nxt = ltxs_pkg::state_stopped_idle;
          else if (t.cur == ltxs_pkg::state_stopped_linked_ack && t.ev == ltxs_pkg::ev_service)
            t.nxt = ltxs_pkg::state_stopped_await_ack;
        end
        default:
        begin
          t.nxt = t.cur;
        end
      endcase
    end
    t.illegal = is_cmd && !legal;
  end
endmodule

/* File: hw/ltxs_err_log.sv */
// Sticky error flag and counter for refused host commands
`timescale 1ns/1ps
module ltxs_err_log (
  input logic aclk,
  input logic aresetn,
  input logic hit,
  input logic clr,
  output logic sticky,
  output logic [15:0] count
);
  ltxs_pkg::ltxs_err_s r;
  ltxs_pkg::ltxs_err_s n;

  // Set wins over a clear in the same cycle; counter saturates
  always_comb
  begin
    n = r;
    if (clr)
      n.sticky = 1'b0;
    if (hit)
    begin
      n.sticky = 1'b1;
      if (r.count != 16'hFFFF)
        n.count = r.count + 16'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  assign sticky = r.sticky;
  assign count = r.count;
endmodule

/* File: hw/ltxs_top.sv */
// Per-link transmit status machine with AXI4-Lite register access
`timescale 1ns/1ps
`include "ltxs_cfg.svh"

// What this block does
// - Stop bit set at once on stop commands
// - Remote disconnect or mode-set frame stops transmit while link_connected is high
// - While stopped, unlink on next service pass
// - Active bit means linked into I queue
// - Relink when command or event enables transmit
// - Ack bit held while frames await acknowledgement
// - Recheck queue before clearing ack bit
// - Transmit bit set while frames remain queued
// - Bit zero marks last link in chain
// - Only eight legal four-bit state codes
// - Queue-data and relink command transitions
// - Stop and teardown command transitions
// - All-acknowledged transitions per queue contents
// - Blocking conditions park sending; clearing resumes
// - Link reset returns word to idle
// - All sent moves sending to awaiting ack
// - Illegal command flags error, changes nothing
module ltxs_top (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic tx_all_sent,
  input logic tx_all_acked,
  input logic tx_queue_nonempty,
  input logic tx_block_cond,
  input logic proto_link_reset,
  input logic rx_disc_or_sabme,
  input logic link_connected,
  input logic link_reset_done,
  input logic tx_service,
  input logic queue_tail_in,
  output logic illegal_command,
  output logic [5:0] mgmt_err_arg,
  output logic [15:0] link_tx_queue_state,
  output logic status_wb_valid,
  output logic [15:0] status_wb_word,
  output logic link_relink,
  output logic link_unlink,
  output logic iframe_tx_allowed
);
  ltxs_pkg::ltxs_top_s r;
  ltxs_pkg::ltxs_top_s n;
  ltxs_pkg::ltxs_event_e ev;
  logic wr_go;
  logic ctrl_wr;
  logic cmd_wr;
  logic err_clr;
  logic take_reset;
  logic take_tear;
  logic take_cmd;
  logic take_ack;
  logic take_sent;
  logic take_svc;
  logic err_sticky;
  logic [15:0] err_count;
  logic [3:0] cur_code;
  logic [3:0] nxt_code;

  ltxs_trans_if tif ();

  // Four-bit stop/active/ack/transmit code of each legal state
  function automatic logic [3:0] state_code(input ltxs_pkg::ltxs_state_e s);
    case (s)
      ltxs_pkg::state_idle: state_code = `LTXS_CODE_IDLE;
      ltxs_pkg::state_await_ack: state_code = `LTXS_CODE_AWAIT_ACK;
      ltxs_pkg::state_blocked: state_code = `LTXS_CODE_BLOCKED;
      ltxs_pkg::state_sending: state_code = `LTXS_CODE_SENDING;
      ltxs_pkg::state_stopped_idle: state_code = `LTXS_CODE_STOPPED_IDLE;
      ltxs_pkg::state_stopped_await_ack: state_code = `LTXS_CODE_STOPPED_AWAIT;
      ltxs_pkg::state_stopped_linked: state_code = `LTXS_CODE_STOPPED_LINKED;
      ltxs_pkg::state_stopped_linked_ack: state_code = `LTXS_CODE_STOPPED_LINKED_ACK;
      default: state_code = `LTXS_CODE_IDLE;
    endcase
  endfunction

  // Host command code to table event; unknown codes do nothing
  function automatic ltxs_pkg::ltxs_event_e cmd_event(input logic [2:0] c);
    case (c)
      `LTXS_CMD_QUEUE_DATA: cmd_event = ltxs_pkg::ev_queue_data;
      `LTXS_CMD_RELINK: cmd_event = ltxs_pkg::ev_relink;
      `LTXS_CMD_STOP: cmd_event = ltxs_pkg::ev_stop_iframes;
      `LTXS_CMD_RELEASE, `LTXS_CMD_DEACTIVATE, `LTXS_CMD_REMOVE, `LTXS_CMD_ESTABLISH:
        cmd_event = ltxs_pkg::ev_teardown;
      default: cmd_event = ltxs_pkg::ev_none;
    endcase
  endfunction

  // Word-aligned address decode, shared by both bus directions
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = ({a[7:2], 2'h0} == `LTXS_OFF_STAT) || ({a[7:2], 2'h0} == `LTXS_OFF_CTRL) ||
      ({a[7:2], 2'h0} == `LTXS_OFF_CMD) || ({a[7:2], 2'h0} == `LTXS_OFF_ERR);
  endfunction

  ltxs_trans u_trans (
    .t(tif.table_side)
  );

  ltxs_err_log u_err (
    .aclk(aclk),
    .aresetn(aresetn),
    .hit(r.illegal),
    .clr(err_clr),
    .sticky(err_sticky),
    .count(err_count)
  );

  // Bus handshakes; one write and one read in flight at a time
  assign s_axi_awready = !r.aw_held && !r.bvalid;
  assign s_axi_wready = !r.w_held && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign wr_go = r.aw_held && r.w_held;
  assign ctrl_wr = wr_go && ({r.waddr[7:2], 2'h0} == `LTXS_OFF_CTRL) && r.wstrb[0];
  assign cmd_wr = wr_go && ({r.waddr[7:2], 2'h0} == `LTXS_OFF_CMD) && r.wstrb[0];
  assign err_clr = wr_go && ({r.waddr[7:2], 2'h0} == `LTXS_OFF_ERR) && r.wstrb[0] &&
    r.wdata[0];

  // Fixed priority: resets first, host commands before link events
  assign take_reset = r.present && r.p_reset;
  assign take_tear = r.present && !r.p_reset && r.p_tear;
  assign take_cmd = r.present && !r.p_reset && !r.p_tear && r.p_cmd;
  assign take_ack = r.present && !r.p_reset && !r.p_tear && !r.p_cmd && r.p_ack;
  assign take_sent = r.present && !r.p_reset && !r.p_tear && !r.p_cmd && !r.p_ack &&
    r.p_sent;
  assign take_svc = r.present && !r.p_reset && !r.p_tear && !r.p_cmd && !r.p_ack &&
    !r.p_sent && r.p_svc;

  // Event fed to the table this cycle
  assign ev = take_reset ? ltxs_pkg::ev_reset :
    take_tear ? ltxs_pkg::ev_teardown :
    take_cmd ? r.cmd_ev :
    take_ack ? (tx_queue_nonempty ? ltxs_pkg::ev_ack_more :
      ltxs_pkg::ev_ack_none) :
    take_sent ? ltxs_pkg::ev_all_sent :
    take_svc ? ltxs_pkg::ev_service :
    (!r.present) ? ltxs_pkg::ev_none :
    (r.state == ltxs_pkg::state_sending && tx_block_cond) ? ltxs_pkg::ev_block :
    (r.state == ltxs_pkg::state_blocked && !tx_block_cond) ? ltxs_pkg::ev_unblock :
    ltxs_pkg::ev_none;

  assign tif.cur = r.state;
  assign tif.ev = ev;
  assign cur_code = state_code(r.state);
  assign nxt_code = state_code(n.state);

  // Next value of all state
  always_comb
  begin
    n = r;
    // Write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_held = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (wr_go)
    begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_hit(r.waddr) ? `LTXS_RESP_OKAY : `LTXS_RESP_SLVERR;
    end
    if (ctrl_wr)
      n.present = r.wdata[`LTXS_CTRL_PRESENT];
    // Read data is captured at the address handshake
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = addr_hit(s_axi_araddr) ? `LTXS_RESP_OKAY : `LTXS_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'h0})
        `LTXS_OFF_STAT: n.rdata = {16'h0000, r.status};
        `LTXS_OFF_CTRL: n.rdata = {31'h00000000, r.present};
        `LTXS_OFF_ERR: n.rdata = {err_count, 2'h0, r.err_arg, 7'h00, err_sticky};
        default: n.rdata = 32'h00000000;
      endcase
    end
    // Consume the event that the table takes this cycle
    if (take_reset)
      n.p_reset = 1'b0;
    if (take_tear)
      n.p_tear = 1'b0;
    if (take_cmd)
      n.p_cmd = 1'b0;
    if (take_ack)
      n.p_ack = 1'b0;
    if (take_sent)
      n.p_sent = 1'b0;
    if (take_svc)
      n.p_svc = 1'b0;
    // Fresh pulses latch after the consume, so none is lost
    n.p_reset = n.p_reset | link_reset_done;
    n.p_tear = n.p_tear | proto_link_reset | (rx_disc_or_sabme & link_connected);
    n.p_ack = n.p_ack | tx_all_acked;
    n.p_sent = n.p_sent | tx_all_sent;
    n.p_svc = n.p_svc | tx_service;
    if (cmd_wr && cmd_event(r.wdata[2:0]) != ltxs_pkg::ev_none)
    begin
      n.p_cmd = 1'b1;
      n.cmd_ev = cmd_event(r.wdata[2:0]);
    end
    // Table result; only legal codes can be reached
    n.state = tif.nxt;
    if (!r.present)
    begin
      // Link not yet presented: word held idle, nothing queued up
      n.state = ltxs_pkg::state_idle;
      n.p_reset = 1'b0;
      n.p_tear = 1'b0;
      n.p_cmd = 1'b0;
      n.p_ack = 1'b0;
      n.p_sent = 1'b0;
      n.p_svc = 1'b0;
    end
  end

  // Status word and side pulses derived from the chosen transition
  ltxs_pkg::ltxs_top_s m;
  always_comb
  begin
    m = n;
    // Upper bits forced to zero; tail bit only meaningful while linked
    m.status = {11'h000, nxt_code, nxt_code[`LTXS_BIT_ACTIVE] & queue_tail_in};
    m.wb = (m.status != r.status);
    m.relink = !cur_code[`LTXS_BIT_ACTIVE] && nxt_code[`LTXS_BIT_ACTIVE];
    m.unlink = cur_code[`LTXS_BIT_ACTIVE] && !nxt_code[`LTXS_BIT_ACTIVE];
    // No I frames go out once stopped, even while still linked
    m.tx_ok = !nxt_code[`LTXS_BIT_STOP] && nxt_code[`LTXS_BIT_ACTIVE] &&
      nxt_code[`LTXS_BIT_TX];
    m.illegal = tif.illegal;
    if (tif.illegal)
      m.err_arg = `LTXS_ERR_ARG;
    // Ack bit comes straight from the state code
    if (nxt_code[`LTXS_BIT_ACK] != cur_code[`LTXS_BIT_ACK])
      m.wb = 1'b1;
  end

  // Register stage for all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= m;
  end

  // Outputs, all from flops except the ready signals
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign illegal_command = r.illegal;
  assign mgmt_err_arg = r.err_arg;
  assign link_tx_queue_state = r.status;
  assign status_wb_valid = r.wb;
  assign status_wb_word = r.status;
  assign link_relink = r.relink;
  assign link_unlink = r.unlink;
  assign iframe_tx_allowed = r.tx_ok;
endmodule

/* File: dv/ltxs_top_asserts.sv */
// Concurrent checks on the ports of the link transmit status block
`timescale 1ns/1ps
module ltxs_top_asserts (
  input logic aclk,
  input logic aresetn,
  input logic proto_link_reset,
  input logic rx_disc_or_sabme,
  input logic link_connected,
  input logic link_reset_done,
  input logic illegal_command,
  input logic [5:0] mgmt_err_arg,
  input logic [15:0] link_tx_queue_state,
  input logic status_wb_valid,
  input logic [15:0] status_wb_word,
  input logic link_relink,
  input logic link_unlink,
  input logic iframe_tx_allowed
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Only eight codes may ever be written, spare bits stay clear
  a_legal_code: assert property (
    link_tx_queue_state[15:5] == 11'h000 &&
    link_tx_queue_state[4:1] inside {4'h0, 4'h2, 4'h3, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE})
    else $error("status word holds an unlisted code");
  // Any change of the word must be copied out in the same cycle
  a_wb_on_change: assert property (
    link_tx_queue_state != $past(link_tx_queue_state) |->
    status_wb_valid && status_wb_word == link_tx_queue_state)
    else $error("status change without write-back");
  // Active rising means the link was put back into its queue
  a_relink_pulse: assert property ($rose(link_tx_queue_state[3]) |-> link_relink)
    else $error("active rose without relink");
  // Active falling means the link was taken out of its queue
  a_unlink_pulse: assert property ($fell(link_tx_queue_state[3]) |-> link_unlink)
    else $error("active fell without unlink");
  // Frames go out only while sending and not stopped
  a_tx_allowed: assert property (
    iframe_tx_allowed == (link_tx_queue_state[4:1] == 4'h7))
    else $error("transmit permission disagrees with status");
  // Tail mark only makes sense while linked into the chain
  a_tail_linked: assert property (link_tx_queue_state[0] |-> link_tx_queue_state[3])
    else $error("tail mark set while unlinked");
  // A refused command reports argument zero and leaves the word alone
  a_illegal_quiet: assert property (
    illegal_command |-> mgmt_err_arg == 6'h00 &&
    link_tx_queue_state == $past(link_tx_queue_state))
    else $error("refused command changed the status");
  // Link reset lands the word in idle two edges later
  a_reset_idle: assert property (
    link_reset_done |-> ##2 link_tx_queue_state[4:1] == 4'h0)
    else $error("link reset did not reach idle");
  // Local or remote link reset raises the stop bit
  a_remote_stop: assert property (
    (proto_link_reset || (rx_disc_or_sabme && link_connected)) && !link_reset_done
    |-> ##2 link_tx_queue_state[4])
    else $error("link reset did not set stop");
endmodule

bind ltxs_top ltxs_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .proto_link_reset(proto_link_reset), .rx_disc_or_sabme(rx_disc_or_sabme),
  .link_connected(link_connected), .link_reset_done(link_reset_done),
  .illegal_command(illegal_command), .mgmt_err_arg(mgmt_err_arg),
  .link_tx_queue_state(link_tx_queue_state), .status_wb_valid(status_wb_valid),
  .status_wb_word(status_wb_word), .link_relink(link_relink),
  .link_unlink(link_unlink), .iframe_tx_allowed(iframe_tx_allowed));

/* File: dv/ltxs_host_mem.sv */
// Host shared-memory copy of the link transmit status word
`timescale 1ns/1ps
module ltxs_host_mem (
  input logic aclk,
  input logic status_wb_valid,
  input logic [15:0] status_wb_word,
  output logic [15:0] mem_word
);
  // Host zeroes the word, spare bits included, before handing it over
  initial mem_word = 16'h0000;
  // Only the block writes the word afterwards
  always @(posedge aclk)
  begin
    if (status_wb_valid === 1'b1)
      mem_word <= status_wb_word;
  end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the link transmit status block
`timescale 1ns/1ps
`include "ltxs_cfg.svh"
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [5:0] evp;
  logic tx_queue_nonempty, tx_block_cond, link_connected, queue_tail_in, ill_seen, blk;
  logic awready, wready, bvalid, arready, rvalid, illegal_command, status_wb_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] mgmt_err_arg;
  logic [15:0] link_tx_queue_state, status_wb_word, mem_word;
  logic [3:0] code;
  int mismatches, total_checks, nill, cyc;
  int seq [8][4] = '{'{0, 0, 0, 0}, '{1, 8, 0, 0}, '{1, 11, 0, 0}, '{1, 0, 0, 0},
    '{4, 0, 0, 0}, '{1, 11, 3, 12}, '{1, 4, 0, 0}, '{1, 3, 0, 0}};

  ltxs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_all_sent(evp[0]),
    .tx_all_acked(evp[1]), .tx_queue_nonempty(tx_queue_nonempty),
    .tx_block_cond(tx_block_cond), .proto_link_reset(evp[3]), .rx_disc_or_sabme(evp[4]),
    .link_connected(link_connected), .link_reset_done(evp[5]), .tx_service(evp[2]),
    .queue_tail_in(queue_tail_in), .illegal_command(illegal_command),
    .mgmt_err_arg(mgmt_err_arg), .link_tx_queue_state(link_tx_queue_state),
    .status_wb_valid(status_wb_valid), .status_wb_word(status_wb_word),
    .link_relink(), .link_unlink(), .iframe_tx_allowed());
  ltxs_host_mem u_host (.aclk(aclk), .status_wb_valid(status_wb_valid),
    .status_wb_word(status_wb_word), .mem_word(mem_word));

  // 10 MHz clock, plus a watchdog so a hung handshake still ends the run
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // Catch the one-cycle refusal pulse between checks
  always @(posedge aclk)
    if (illegal_command === 1'b1) ill_seen <= 1'b1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes judged at the falling edge, where every signal has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic da, dw;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    da = 1'b0; dw = 1'b0;
    while (!(da && dw))
    begin
      @(negedge aclk);
      if (awready === 1'b1) da = 1'b1;
      if (wready === 1'b1) dw = 1'b1;
      @(posedge aclk);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic pulse(input int k);
    @(posedge aclk);
    evp <= 6'(1 << k);
    @(posedge aclk);
    evp <= 6'h00;
  endtask

  // Expected code after one command or event; stop states ignore block level
  function automatic logic [3:0] nxt_code(input logic [3:0] c, input int op, output logic il);
    il = 1'b0;
    nxt_code = c;
    case (op)
      1: if (c == 4'h0 || c == 4'h8 || c == 4'hC) nxt_code = 4'h7; else il = 1'b1;
      2: if (c == 4'h2) nxt_code = 4'h7; else if (c != 4'h3 && c != 4'h7) il = 1'b1;
      3: if (c == 4'h3) nxt_code = 4'hA; else if (c == 4'h7) nxt_code = 4'hE; else il = 1'b1;
      4, 5, 6, 7, 14, 15: nxt_code = (c == 4'h7 || c == 4'hC || c == 4'hE) ? 4'hC : 4'h8;
      8: if (c == 4'h7) nxt_code = 4'h2;
      9, 10: if (c == 4'h2) nxt_code = (op == 10) ? 4'h7 : 4'h0;
        else if (c == 4'hA || c == 4'hE) nxt_code = 4'h8;
      13: if (c == 4'hC) nxt_code = 4'h8; else if (c == 4'hE) nxt_code = 4'hA;
      17: nxt_code = 4'h0;
      default: nxt_code = c;
    endcase
  endfunction

  // One command or event, then the word is compared on every view
  task automatic step(input int op);
    logic [3:0] n;
    logic il, tl;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] w;
    tl = 1'($urandom_range(1, 0));
    @(posedge aclk);
    queue_tail_in <= tl;
    ill_seen = 1'b0;
    case (op)
      1, 2, 3, 4, 5, 6, 7: wr(`LTXS_OFF_CMD, 32'(op), r);
      8: pulse(0);
      9, 10: begin tx_queue_nonempty <= (op == 10); pulse(1); end
      11: tx_block_cond <= 1'b1;
      12: tx_block_cond <= 1'b0;
      13: pulse(2);
      14: pulse(3);
      15: pulse(4);
      16: begin link_connected <= 1'b0; pulse(4); link_connected <= 1'b1; end
      default: pulse(5);
    endcase
    repeat (6) @(posedge aclk);
    n = nxt_code(code, op, il);
    if (op == 11) blk = 1'b1;
    if (op == 12) blk = 1'b0;
    if (blk && n == 4'h7) n = 4'h3; else if (!blk && n == 4'h3) n = 4'h7;
    code = n;
    nill += int'(il);
    w = {11'h000, n, n[2] & tl};
    chk("refusal", 32'(il), 32'(ill_seen));
    chk("status port", 32'(w), 32'(link_tx_queue_state));
    chk("host copy", 32'(w), 32'(mem_word));
    rd(`LTXS_OFF_STAT, d, r);
    chk("status reg", 32'(w), d);
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset, register access, full state and event sweep, then random traffic
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] codes [8] = '{4'h0, 4'h2, 4'h3, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE};
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'hF; evp = 6'h00; tx_queue_nonempty = 1'b0; tx_block_cond = 1'b0;
    link_connected = 1'b1; queue_tail_in = 1'b0; ill_seen = 1'b0; blk = 1'b0;
    code = 4'h0;
    void'($urandom(32'hD2B7));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LTXS_OFF_STAT, d, r);
    chk("status reset", 32'h0, d);
    wr(`LTXS_OFF_STAT, 32'hFFFF, r);
    rd(`LTXS_OFF_STAT, d, r);
    chk("status read-only", 32'h0, d);
    wr(8'h10, 32'h1, r);
    chk("unmapped write", 32'h2, 32'(r));
    rd(8'h10, d, r);
    chk("unmapped read", 32'h2, 32'(r));
    wr(`LTXS_OFF_CTRL, 32'h1, r);
    $display("Test register access done");
    foreach (codes[s])
      for (int op = 1; op <= 17; op++)
      begin
        step(12);
        step(17);
        for (int j = 0; j < 4; j++)
          if (seq[s][j] != 0) step(seq[s][j]);
        chk("start state", 32'(codes[s]), 32'(code));
        step(op);
      end
    $display("Test state sweep done");
    repeat (120) step($urandom_range(17, 1));
    $display("Test random traffic done");
    rd(`LTXS_OFF_ERR, d, r);
    chk("err count", 32'(nill), 32'(d[31:16]));
    chk("err arg", 32'h0, 32'(d[13:8]));
    wr(`LTXS_OFF_ERR, 32'h1, r);
    rd(`LTXS_OFF_ERR, d, r);
    chk("err sticky clear", 32'h0, 32'(d[0]));
    $display("Test error log done");
    finish_test();
  end
endmodule
